/* File: sfs_pkg.sv */
// Purpose: Shared constants and types of the serial flash command block
// Assumes: ref_clk at 100 MHz samples the serial link
// Notes:   Status byte layout, command codes, phase lengths, timing
package sfs_pkg;

    // Command codes
    localparam logic [7:0] CMD_STATUS_WRITE    = 8'h01;
    localparam logic [7:0] CMD_READ            = 8'h03;
    localparam logic [7:0] CMD_STATUS_READ     = 8'h05;
    localparam logic [7:0] CMD_WRITE_LATCH_SET = 8'h06;
    localparam logic [7:0] CMD_FAST_READ       = 8'h0B;
    localparam logic [7:0] CMD_DUAL_OUT        = 8'h3B;
    localparam logic [7:0] CMD_DUAL_IO         = 8'hBB;
    localparam logic [7:0] CMD_QUAD_IO         = 8'hEB;

    // Status byte fields and reset value
    localparam int         SR_WIP       = 0;
    localparam int         SR_WEL       = 1;
    localparam int         SR_SRP       = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Phase lengths in serial clocks
    localparam logic [5:0] CMD_LAST        = 6'h07;
    localparam logic [5:0] DATA_BYTE_BITS  = 6'h08;
    localparam logic [5:0] WDATA_SAT       = 6'h09;
    localparam logic [5:0] MODE_LAST       = 6'h01;
    localparam logic [3:0] DUMMY_FAST      = 4'h8;
    localparam logic [3:0] DUMMY_DUAL_IO   = 4'h4;
    localparam logic [3:0] DUMMY_QUAD      = 4'h4;

    // Self-timed status write cycle
    localparam int          CLK_PERIOD_NS          = 10;
    localparam int          STATUS_WRITE_CYCLE_NS  = 5000;
    localparam logic [15:0] STATUS_WRITE_CYCLES    =
        16'((STATUS_WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Reset value of the synchronisers: chip select idle high
    localparam logic [6:0] SYNC_RESET = 7'h40;

    typedef enum logic [6:0] {
        ST_CMD    = 7'h01,
        ST_ADDR   = 7'h02,
        ST_MODE   = 7'h04,
        ST_DUMMY  = 7'h08,
        ST_DATA   = 7'h10,
        ST_WDATA  = 7'h20,
        ST_IGNORE = 7'h40
    } sfs_state_e;

endpackage : sfs_pkg

/* File: sfs_buf_if.sv */
// Purpose: Carrier between the command core and its read data buffer
// Assumes: Both ends on ref_clk
// Notes:   fill is the core side, store the buffer side
`timescale 1ns/1ps
interface sfs_buf_if #(
    parameter int WIDTH = 8
);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;
    logic             flush;

    modport fill  (output push_valid, push_data, pop_ready, flush,
                   input  push_ready, pop_valid, pop_data);
    modport store (input  push_valid, push_data, pop_ready, flush,
                   output push_ready, pop_valid, pop_data);
endinterface : sfs_buf_if

/* File: sfs_pair_buf.sv */
// Purpose: Small flop buffer with valid and ready on both sides
// Assumes: DEPTH of at least two
// Notes:   Flush wins over a push in the same cycle
`timescale 1ns/1ps
module sfs_pair_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic ref_clk,
    input wire logic rstn,
    sfs_buf_if.store bus
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [CW-1:0]               cnt;
    } sfs_buf_s;

    sfs_buf_s q;
    sfs_buf_s d;
    logic     push;
    logic     pop;

    // Honest full and empty straight from the count
    assign bus.push_ready = (q.cnt != CW'(DEPTH));
    assign bus.pop_valid  = (q.cnt != '0);
    assign bus.pop_data   = q.mem[q.rp];
    assign push           = bus.push_valid & bus.push_ready;
    assign pop            = bus.pop_valid & bus.pop_ready;

    // Next state; pointers wrap for any depth
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = bus.push_data;
            d.wp        = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + PW'(1);
        end
        if (pop) begin
            d.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + PW'(1);
        end
        d.cnt = q.cnt + CW'(push) - CW'(pop);
        if (bus.flush) begin
            d.wp  = '0;
            d.rp  = '0;
            d.cnt = '0;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : sfs_pair_buf

/* File: sfs_flash_core.sv */
// Purpose: Serial flash command handling for status write and all reads
// Assumes: Link pins are asynchronous and sampled by ref_clk, serial clock well below ref_clk / 8
// Notes:   Memory bytes prefetched through a two-entry buffer, so the fetch address leads the output
`timescale 1ns/1ps
module sfs_flash_core #(
    parameter int ADDR_W = 24
) (
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              spi_sclk,
    input  wire logic              spi_cs_n,
    input  wire logic              wp_n,
    input  wire logic [3:0]        io_in,
    output logic      [3:0]        io_out,
    output logic      [3:0]        io_oe,
    output logic      [ADDR_W-1:0] mem_addr,
    input  wire logic [7:0]        mem_rdata,
    input  wire logic              mem_rvalid,
    output logic                   mem_rready,
    output logic      [7:0]        status_byte,
    output logic                   continuous_mode
);
    typedef struct packed {
        logic [6:0]         sync1;
        logic [6:0]         sync2;
        logic               sclk_prev;
        logic               cs_prev;
        sfs_pkg::sfs_state_e state;
        logic [7:0]         cmd;
        logic [23:0]        shreg;
        logic [5:0]         bitcnt;
        logic [2:0]         lanes;
        logic [2:0]         dlanes;
        logic [3:0]         dummy;
        logic               has_mode;
        logic [7:0]         out_sh;
        logic [3:0]         out_cnt;
        logic [3:0]         io_out;
        logic [3:0]         io_oe;
        logic [ADDR_W-1:0]  addr;
        logic               fetch_en;
        logic [7:0]         status;
        logic [15:0]        wcnt;
        logic               cont;
    } sfs_core_s;

    sfs_core_s   q;
    sfs_core_s   n;
    logic        sclk_s;
    logic        cs_s;
    logic        wp_s;
    logic [3:0]  io_s;
    logic        rise;
    logic        fall;
    logic        cs_fall;
    logic        cs_rise;
    logic        hardware_protected_mode;
    logic        push_acc;
    logic        pop_c;
    logic        flush_c;
    logic        write_latch_set_cmd_ok;
    logic        wsr_ok;
    logic        rd_reject;
    logic        mode_bad;
    logic [23:0] sh_c;
    logic [7:0]  byte_c;
    logic [5:0]  addr_last;

    sfs_buf_if #(.WIDTH(8)) bq ();

    sfs_pair_buf #(.WIDTH(8), .DEPTH(2)) u_buf (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .bus     (bq.store)
    );

    // Shift in one clock's worth of bits, top line is the nibble MSB
    function automatic logic [23:0] sfs_shift(input logic [23:0] s, input logic [3:0] io, input logic [2:0] w);
        case (w)
            3'h2:    return {s[21:0], io[1:0]};
            3'h4:    return {s[19:0], io};
            default: return {s[22:0], io[0]};
        endcase
    endfunction : sfs_shift

    // Present the top bits of a byte on the active lines
    function automatic logic [3:0] sfs_lane_out(input logic [7:0] b, input logic [2:0] w);
        case (w)
            3'h2:    return {2'h0, b[7:6]};
            3'h4:    return b[7:4];
            default: return {2'h0, b[7], 1'b0};
        endcase
    endfunction : sfs_lane_out

    // Only the second synchroniser stage is read by logic
    assign sclk_s    = q.sync2[5];
    assign cs_s      = q.sync2[6];
    assign wp_s      = q.sync2[4];
    assign io_s      = q.sync2[3:0];
    assign rise      = !cs_s && sclk_s && !q.sclk_prev;
    assign fall      = !cs_s && !sclk_s && q.sclk_prev;
    assign cs_fall   = !cs_s && q.cs_prev;
    assign cs_rise   = cs_s && !q.cs_prev;
    assign hardware_protected_mode       = q.status[sfs_pkg::SR_SRP] && !wp_s;
    assign addr_last = (q.lanes == 3'h4) ? 6'h05 : (q.lanes == 3'h2) ? 6'h0B : 6'h17;
    assign sh_c      = sfs_shift(q.shreg, io_s, q.lanes);

    // Memory fetch side of the buffer; stalls while the buffer is full
    assign bq.push_valid = mem_rvalid && q.fetch_en;
    assign bq.push_data  = mem_rdata;
    assign bq.pop_ready  = pop_c;
    assign bq.flush      = flush_c;
    assign mem_rready    = q.fetch_en && bq.push_ready;
    assign push_acc      = bq.push_valid && bq.push_ready;

    assign io_out          = q.io_out;
    assign io_oe           = q.io_oe;
    assign mem_addr        = q.addr;
    assign status_byte     = q.status;
    assign continuous_mode = q.cont;

    // Whole next-state function
    always_comb begin
        n         = q;
        pop_c     = 1'b0;
        flush_c   = 1'b0;
        write_latch_set_cmd_ok   = 1'b0;
        wsr_ok    = 1'b0;
        rd_reject = 1'b0;
        mode_bad  = 1'b0;
        byte_c    = 8'h00;
        n.sync1     = {spi_cs_n, spi_sclk, wp_n, io_in};
        n.sync2     = q.sync1;
        n.sclk_prev = sclk_s;
        n.cs_prev   = cs_s;

        // Self-timed status write; status stays readable meanwhile
        if (q.status[sfs_pkg::SR_WIP]) begin
            if (q.wcnt == sfs_pkg::STATUS_WRITE_CYCLES - 16'h0001) begin
                n.status[sfs_pkg::SR_WIP] = 1'b0;
                n.status[sfs_pkg::SR_WEL] = 1'b0;
            end else begin
                n.wcnt = q.wcnt + 16'h0001;
            end
        end

        // Prefetch address advances per byte and wraps at the top
        if (push_acc) begin
            n.addr = q.addr + ADDR_W'(1);
        end

        // Input side: sample on the rising serial edge
        if (rise) begin
            n.shreg  = sh_c;
            n.bitcnt = q.bitcnt + 6'h01;
            case (q.state)
                sfs_pkg::ST_CMD: begin
                    if (q.bitcnt == sfs_pkg::CMD_LAST) begin
                        n.cmd      = sh_c[7:0];
                        n.bitcnt   = 6'h00;
                        n.state    = sfs_pkg::ST_ADDR;
                        n.has_mode = 1'b0;
                        n.dummy    = 4'h0;
                        n.lanes    = 3'h1;
                        n.dlanes   = 3'h1;
                        case (sh_c[7:0])
                            sfs_pkg::CMD_READ: begin
                                n.dummy = 4'h0;
                            end
                            sfs_pkg::CMD_FAST_READ: begin
                                n.dummy = sfs_pkg::DUMMY_FAST;
                            end
                            sfs_pkg::CMD_DUAL_OUT: begin
                                n.dummy  = sfs_pkg::DUMMY_FAST;
                                n.dlanes = 3'h2;
                            end
                            sfs_pkg::CMD_DUAL_IO: begin
                                n.lanes  = 3'h2;
                                n.dlanes = 3'h2;
                                n.dummy  = sfs_pkg::DUMMY_DUAL_IO;
                            end
                            sfs_pkg::CMD_QUAD_IO: begin
                                n.lanes    = 3'h4;
                                n.dlanes   = 3'h4;
                                n.has_mode = 1'b1;
                                n.dummy    = sfs_pkg::DUMMY_QUAD;
                            end
                            sfs_pkg::CMD_STATUS_READ: n.state = sfs_pkg::ST_DATA;
                            sfs_pkg::CMD_STATUS_WRITE: n.state = sfs_pkg::ST_WDATA;
                            sfs_pkg::CMD_WRITE_LATCH_SET: n.state = sfs_pkg::ST_WDATA;
                            default: n.state = sfs_pkg::ST_IGNORE;
                        endcase
                        // A busy device refuses every read but the status read
                        if (q.status[sfs_pkg::SR_WIP] && n.state == sfs_pkg::ST_ADDR) begin
                            n.state   = sfs_pkg::ST_IGNORE;
                            rd_reject = 1'b1;
                        end
                    end
                end
                sfs_pkg::ST_ADDR: begin
                    if (q.bitcnt == addr_last) begin
                        n.addr     = sh_c[ADDR_W-1:0];
                        n.fetch_en = 1'b1;
                        flush_c    = 1'b1;
                        n.bitcnt   = 6'h00;
                        n.state    = q.has_mode ? sfs_pkg::ST_MODE :
                                     (q.dummy != 4'h0) ? sfs_pkg::ST_DUMMY : sfs_pkg::ST_DATA;
                    end
                end
                sfs_pkg::ST_MODE: begin
                    if (q.bitcnt == sfs_pkg::MODE_LAST) begin
                        n.cont   = (sh_c[7:4] == ~sh_c[3:0]);
                        mode_bad = (sh_c[7:4] != ~sh_c[3:0]);
                        n.bitcnt = 6'h00;
                        n.state  = sfs_pkg::ST_DUMMY;
                    end
                end
                sfs_pkg::ST_DUMMY: begin
                    if (q.bitcnt == {2'h0, q.dummy - 4'h1}) begin
                        n.bitcnt = 6'h00;
                        n.state  = sfs_pkg::ST_DATA;
                    end
                end
                sfs_pkg::ST_WDATA: begin
                    if (q.bitcnt == sfs_pkg::WDATA_SAT) begin
                        n.bitcnt = q.bitcnt;
                    end
                end
                default: begin
                    n.bitcnt = q.bitcnt;
                end
            endcase
        end

        // Output side: shift on the falling serial edge
        if (fall && q.state == sfs_pkg::ST_DATA) begin
            if (q.out_cnt == 4'h0) begin
                if (q.cmd == sfs_pkg::CMD_STATUS_READ) begin
                    byte_c = q.status;
                end else begin
                    byte_c = bq.pop_data;
                    pop_c  = bq.pop_valid;
                end
                n.out_cnt = (q.dlanes == 3'h4) ? 4'h1 : (q.dlanes == 3'h2) ? 4'h3 : 4'h7;
            end else begin
                byte_c    = q.out_sh;
                n.out_cnt = q.out_cnt - 4'h1;
            end
            n.io_out = sfs_lane_out(byte_c, q.dlanes);
            n.out_sh = 8'(byte_c << q.dlanes);
            n.io_oe  = (q.dlanes == 3'h4) ? 4'hF : (q.dlanes == 3'h2) ? 4'h3 : 4'h2;
        end

        // New frame; continuous mode starts straight at the address
        if (cs_fall) begin
            n.bitcnt   = 6'h00;
            n.out_cnt  = 4'h0;
            n.io_oe    = 4'h0;
            n.lanes    = 3'h1;
            n.dlanes   = 3'h1;
            n.has_mode = 1'b0;
            n.dummy    = 4'h0;
            n.state    = sfs_pkg::ST_CMD;
            if (q.cont) begin
                n.cmd      = sfs_pkg::CMD_QUAD_IO;
                n.lanes    = 3'h4;
                n.dlanes   = 3'h4;
                n.has_mode = 1'b1;
                n.dummy    = sfs_pkg::DUMMY_QUAD;
                n.state    = q.status[sfs_pkg::SR_WIP] ? sfs_pkg::ST_IGNORE : sfs_pkg::ST_ADDR;
                rd_reject  = q.status[sfs_pkg::SR_WIP];
            end
        end

        // Frame end: release the lines, then commit any write command
        if (cs_rise) begin
            n.state    = sfs_pkg::ST_CMD;
            n.io_oe    = 4'h0;
            n.fetch_en = 1'b0;
            flush_c    = 1'b1;
            if (q.state == sfs_pkg::ST_WDATA && !q.status[sfs_pkg::SR_WIP]) begin
                if (q.cmd == sfs_pkg::CMD_WRITE_LATCH_SET && q.bitcnt == 6'h00) begin
                    write_latch_set_cmd_ok                   = 1'b1;
                    n.status[sfs_pkg::SR_WEL] = 1'b1;
                end
                // Exactly eight data bits, latch set, not locked
                if (q.cmd == sfs_pkg::CMD_STATUS_WRITE && q.bitcnt == sfs_pkg::DATA_BYTE_BITS
                    && q.status[sfs_pkg::SR_WEL] && !hardware_protected_mode) begin
                    wsr_ok                    = 1'b1;
                    n.status[7:2]             = q.shreg[7:2];
                    n.status[sfs_pkg::SR_WIP] = 1'b1;
                    n.wcnt                    = 16'h0000;
                end
            end
        end
    end

    // State register; volatile flags clear at power-up
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            q          <= '0;
            q.sync1    <= sfs_pkg::SYNC_RESET;
            q.sync2    <= sfs_pkg::SYNC_RESET;
            q.cs_prev  <= 1'b1;
            q.state    <= sfs_pkg::ST_CMD;
            q.lanes    <= 3'h1;
            q.dlanes   <= 3'h1;
            q.status   <= sfs_pkg::STATUS_RESET;
        end else begin
            q <= n;
        end
    end

    property p_wel_first;
        @(posedge ref_clk) disable iff (!rstn) $rose(q.status[0]) |-> $past(q.status[1]);
    endproperty
    a_wel_first: assert property (p_wel_first) else $error("write cycle without latch");

    property p_on_cs_rise;
        @(posedge ref_clk) disable iff (!rstn) $rose(q.status[0]) |-> $past(cs_rise) && $past(q.bitcnt) == 6'h08;
    endproperty
    a_on_cs_rise: assert property (p_on_cs_rise) else $error("write cycle not at select rise");

    property p_busy_holds;
        @(posedge ref_clk) disable iff (!rstn) $rose(q.status[0]) |-> q.status[1] ##1 q.status[0] [*8];
    endproperty
    a_busy_holds: assert property (p_busy_holds) else $error("busy flag dropped early");

    property p_busy_ends;
        @(posedge ref_clk) disable iff (!rstn) $rose(q.status[0]) |-> ##[499:501] !q.status[0];
    endproperty
    a_busy_ends: assert property (p_busy_ends) else $error("write cycle length wrong");

    property p_wel_cleared;
        @(posedge ref_clk) disable iff (!rstn) $fell(q.status[0]) |-> !q.status[1];
    endproperty
    a_wel_cleared: assert property (p_wel_cleared) else $error("latch not cleared after cycle");

    property p_locked;
        @(posedge ref_clk) disable iff (!rstn) $rose(q.status[0]) |-> !$past(hardware_protected_mode);
    endproperty
    a_locked: assert property (p_locked) else $error("status written while protected");

    property p_release;
        @(posedge ref_clk) disable iff (!rstn) cs_s |=> q.io_oe == 4'h0;
    endproperty
    a_release: assert property (p_release) else $error("lines driven while deselected");

    property p_reject;
        @(posedge ref_clk) disable iff (!rstn) rd_reject |=> q.state == sfs_pkg::ST_IGNORE && q.io_oe == 4'h0;
    endproperty
    a_reject: assert property (p_reject) else $error("read not rejected while busy");

    property p_latch_set;
        @(posedge ref_clk) disable iff (!rstn) write_latch_set_cmd_ok |=> q.status[1];
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch-set did not set latch");

    property p_leave_cont;
        @(posedge ref_clk) disable iff (!rstn) mode_bad |=> !q.cont;
    endproperty
    a_leave_cont: assert property (p_leave_cont) else $error("continuous mode kept");

    property p_addr_step;
        @(posedge ref_clk) disable iff (!rstn) push_acc && !flush_c |=> q.addr - $past(q.addr) == ADDR_W'(1);
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("fetch address did not advance");
endmodule : sfs_flash_core

/* File: sfs_host_model.sv */
// Purpose: Host controller model on the flash link
// Assumes: Mode 0, sclk parked low outside frames
// Notes:   Released lines show the inverse of the last level
`timescale 1ns/1ps
module sfs_host_model (
    output logic            spi_sclk,
    output logic            spi_cs_n,
    output logic      [3:0] io_in,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe
);
    logic [3:0] h_en;
    logic [3:0] h_val;
    // Line level; inverse when nobody drives, so no stale value passes
    always_comb begin
        for (int i = 0; i < 4; i++) io_in[i] = io_oe[i] ? io_out[i] : h_en[i] ? h_val[i] : ~h_val[i];
    end
    // Idle and deselected
    initial begin
        {spi_sclk, spi_cs_n, h_en, h_val} = 10'h100;
    end
    task automatic sel();
        spi_cs_n = 1'b0;
    endtask : sel
    task automatic desel();
        h_en = 4'h0;
        spi_cs_n = 1'b1;
        #100;
    endtask : desel
    // n clocks of l lanes, bits taken on the rising edge
    task automatic send(input int l, input int n, input logic [23:0] v);
        logic [23:0] s;
        s = v << (24 - n * l);
        h_en = 4'((1 << l) - 1);
        for (int k = 0; k < n; k++) begin
            h_val = 4'(s[23:20] >> (4 - l));
            s = s << l;
            #62.5 spi_sclk = 1'b1;
            #62.5 spi_sclk = 1'b0;
        end
    endtask : send
    // One byte in; sampled just before the rising edge
    task automatic recv(input int l, output logic [7:0] v);
        h_en = 4'h0;
        v = 8'h00;
        for (int k = 0; k < 8 / l; k++) begin
            #62.5 v = (v << l) | 8'((l == 1) ? {3'h0, io_in[1]} : (io_in & 4'((1 << l) - 1)));
            spi_sclk = 1'b1;
            #62.5 spi_sclk = 1'b0;
        end
    endtask : recv
endmodule : sfs_host_model

/* File: tb_top.sv */
// Purpose: Self-checking bench of the flash command core
// Assumes: Host model on the link, behavioural memory
// Notes:   Seeded random data, addresses and memory stalls
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] SW = sfs_pkg::CMD_STATUS_WRITE;
    localparam logic [7:0] WL = sfs_pkg::CMD_WRITE_LATCH_SET;
    logic        ref_clk, rstn, wp_n, mem_rvalid, mem_rready, cont_mode, spi_sclk, spi_cs_n;
    logic [3:0]  io_in, io_out, io_oe;
    logic [23:0] mem_addr, a;
    logic [7:0]  mem_rdata, status_byte, d, v;
    int          n_errors, checks, seed;
    // Per variant: command, address lanes, dummy clocks, data lanes
    logic [7:0]  cmd_t [6] = '{sfs_pkg::CMD_READ, sfs_pkg::CMD_FAST_READ, sfs_pkg::CMD_DUAL_OUT,
                               sfs_pkg::CMD_DUAL_IO, sfs_pkg::CMD_QUAD_IO, 8'h00};
    int          la_t [6] = '{1, 1, 1, 2, 4, 4};
    int          dc_t [6] = '{0, 8, 8, 4, 4, 4};
    int          ld_t [6] = '{1, 1, 2, 2, 4, 4};
    sfs_flash_core #(.ADDR_W(24)) dut_u (.ref_clk(ref_clk), .rstn(rstn), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .wp_n(wp_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .mem_rready(mem_rready), .status_byte(status_byte),
        .continuous_mode(cont_mode));
    sfs_host_model host_u (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
    function automatic logic [7:0] mem_byte(input logic [23:0] x);
        return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h3C;
    endfunction : mem_byte
    // Memory answers at once; random stalls never two in a row, so prefetch stays ahead
    assign mem_rdata = mem_byte(mem_addr);
    always @(posedge ref_clk) mem_rvalid <= #1 !mem_rvalid || (($random(seed) & 3) != 0);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    task automatic frame(input logic [7:0] c, input int n, input logic [23:0] x);
        host_u.sel();
        host_u.send(1, 8, 24'(c));
        host_u.send(1, n, x);
        host_u.desel();
    endtask : frame
    // Busy flag clears within the write cycle plus margin
    task automatic wait_idle();
        int t;
        for (t = 0; t < 700 && status_byte[0] !== 1'b0; t++) begin
            @(posedge ref_clk);
            #1;
        end
        if (t == 700) begin
            n_errors++;
            test_done();
        end
    endtask : wait_idle
    task automatic rd(input int k, input logic [23:0] ad, input logic [7:0] md, input bit busy);
        logic [7:0] r;
        host_u.sel();
        if (k < 5) host_u.send(1, 8, 24'(cmd_t[k]));
        host_u.send(la_t[k], 24 / la_t[k], ad);
        if (la_t[k] == 4) host_u.send(4, 2, 24'(md));
        host_u.send(la_t[k], dc_t[k], 24'($random(seed)));
        for (int i = 0; i < (busy ? 1 : 3); i++) begin
            host_u.recv(ld_t[k], r);
            if (busy) chk({4'h0, io_oe}, 8'h00);
            else chk(r, mem_byte(ad + 24'(i)));
        end
        host_u.desel();
        chk({4'h0, io_oe}, 8'h00);
        chk({7'h0, mem_rready}, 8'h00);
    endtask : rd
    initial begin
        {seed, rstn, wp_n, mem_rvalid, n_errors, checks} = {32'd58188, 3'b011, 64'd0};
        repeat (4) @(posedge ref_clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        chk(status_byte, 8'h00);
        frame(SW, 8, 24'hFC);
        chk(status_byte, 8'h00);
        frame(WL, 0, 24'h0);
        chk(status_byte, 8'h02);
        frame(SW, 9, 24'h1FC);
        chk(status_byte, 8'h02);
        d = 8'($random(seed)) | 8'h80;
        frame(SW, 8, 24'(d));
        chk(status_byte, {d[7:2], 2'b11});
        host_u.sel();
        host_u.send(1, 8, 24'(sfs_pkg::CMD_STATUS_READ));
        host_u.recv(1, v);
        host_u.desel();
        chk(v, {d[7:2], 2'b11});
        rd(4, 24'h0, 8'hFF, 1'b1);
        wait_idle();
        chk(status_byte, {d[7:2], 2'b00});
        wp_n = 1'b0;
        frame(WL, 0, 24'h0);
        frame(SW, 8, 24'h0);
        chk(status_byte, {d[7:2], 2'b10});
        wp_n = 1'b1;
        frame(WL, 0, 24'h0);
        frame(SW, 8, 24'h0);
        chk(status_byte, 8'h03);
        rd(0, 24'h0, 8'hFF, 1'b1);
        wait_idle();
        $display("status write tests done");
        for (int k = 0; k < 5; k++) rd(k, (k == 0) ? 24'hFFFFFF : 24'($random(seed)), 8'hFF, 1'b0);
        a = 24'($random(seed));
        rd(4, a, 8'hA5, 1'b0);
        chk({7'h0, cont_mode}, 8'h01);
        rd(5, a, 8'hFF, 1'b0);
        chk({7'h0, cont_mode}, 8'h00);
        $display("read tests done");
        test_done();
    end
endmodule : tb_top
